// ===== bench/tb_wep_regs.sv
`timescale 1ns/1ns
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, a); end end
module tb_wep_regs;
	import wep_pkg::*;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, standby_supply = 1'b1, thermal_shutdown = 1'b0;
	logic panel_switch_input = 1'b0, key_wake = 1'b0, pointer_wake = 1'b0;
	logic key_code_valid = 1'b0, power_restored = 1'b0, prior_state_on = 1'b0;
	logic [9:0] paddr = 10'h0;
	logic [31:0] pwdata = 32'h0, prdata;
	logic [7:0] key_code = 8'h0, rd;
	logic pready, pslverr, er, lo, any_key_mode, hunting, power_request_out_n, irq;
	int errors = 0, num_checks = 0;
	wep_regs dut (.*);
	always #5 clk = ~clk;
	// one apb transfer, waits for pready
	task apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		@(posedge clk);
		{psel, penable, pwrite} <= {2'b10, w};
		paddr <= {i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata[7:0];
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task rchk(input logic [7:0] i, input logic [7:0] e, input string n);
		apb(1'b0, i, 8'h0);
		`CHK(n, e, rd)
	endtask
	// one-cycle pulses of restore, pointer, key
	task kick(input logic [2:0] m);
		@(posedge clk);
		{power_restored, pointer_wake, key_wake} <= m;
		@(posedge clk);
		{power_restored, pointer_wake, key_wake} <= 3'b000;
		#1;
		lo = !power_request_out_n;
	endtask
	task t_reset;
		rchk(WEP_IDX_KEY_INDEX, 8'h00, "index");
		rchk(WEP_IDX_KEY_DATA, 8'hFF, "data");
		rchk(WEP_IDX_LOSS_CTRL, 8'h00, "ctrl");
		rchk(WEP_IDX_EVT_STATUS, 8'h08, "status");
		rchk(WEP_IDX_EVT_STATUS, 8'h00, "st_clr");
		apb(1'b0, 8'hF0, 8'h0);
		`CHK("slverr", 1'b1, er)
	endtask
	task t_keys;
		logic [7:0] ix [4] = '{8'h00, 8'h0E, 8'h3E, 8'h40};
		for (int k = 0; k < 8; k++) begin
			apb(1'b1, WEP_IDX_KEY_INDEX, ix[k % 4]);
			if (k < 4)
				apb(1'b1, WEP_IDX_KEY_DATA, 8'(k * 8'h11 + 8'h21));
			else
				rchk(WEP_IDX_KEY_DATA, 8'((k - 4) * 8'h11 + 8'h21), "keys");
		end
		apb(1'b1, WEP_IDX_KEY_INDEX, 8'h0F);
		rchk(WEP_IDX_KEY_DATA, 8'hFF, "gap");
	endtask
	task t_live;
		@(posedge clk);
		{key_code_valid, key_code} <= 9'h155;
		@(posedge clk);
		key_code <= 8'h66;
		@(posedge clk);
		key_code_valid <= 1'b0;
		apb(1'b1, WEP_IDX_KEY_INDEX, 8'h10);
		rchk(WEP_IDX_KEY_DATA, 8'h66, "live0");
		apb(1'b1, WEP_IDX_KEY_INDEX, 8'h11);
		rchk(WEP_IDX_KEY_DATA, 8'h55, "live1");
	endtask
	task t_events;
		@(posedge clk);
		{standby_supply, thermal_shutdown, panel_switch_input} <= 3'b011;
		repeat (6) @(posedge clk);
		standby_supply <= 1'b1;
		repeat (6) @(posedge clk);
		kick(3'b011);
		rchk(WEP_IDX_EVT_STATUS, 8'h2F, "events");
		rchk(WEP_IDX_EVT_STATUS, 8'h00, "ev_clr");
	endtask
	// ctrl, wake ctrl, prior on, decision on
	task t_loss;
		logic [17:0] v [7] = '{{16'h0000, 2'b00}, {16'h8000, 2'b00},
			{16'hA000, 2'b01}, {16'hC000, 2'b11}, {16'hC000, 2'b00},
			{16'hE010, 2'b00}, {16'hE000, 2'b01}};
		for (int k = 0; k < 7; k++) begin
			apb(1'b1, WEP_IDX_LOSS_CTRL, v[k][17:10]);
			apb(1'b1, WEP_IDX_WAKE_CTRL, v[k][9:2]);
			prior_state_on <= v[k][1];
			kick(3'b100);
			`CHK("loss_req", v[k][0] & v[k][17], lo)
			rchk(WEP_IDX_EVT_STATUS, {3'b000, v[k][17] & ~v[k][0], 4'h0}, "loss");
		end
	endtask
	task t_wake;
		apb(1'b1, WEP_IDX_LOSS_CTRL, 8'h0C);
		#1;
		`CHK("anykey", 1'b1, any_key_mode)
		`CHK("hunt", 1'b1, hunting)
		apb(1'b1, WEP_IDX_WAKE_CTRL, 8'h40);
		kick(3'b001);
		`CHK("key_req", 1'b1, lo)
		`CHK("hunt_clr", 1'b0, hunting)
		apb(1'b1, WEP_IDX_WAKE_CTRL, 8'h00);
		kick(3'b001);
		`CHK("key_noreq", 1'b0, lo)
		rchk(WEP_IDX_EVT_STATUS, 8'h01, "keyflag");
	endtask
	task t_irq;
		apb(1'b1, WEP_IDX_IRQ_STATUS, 8'hFF);
		apb(1'b1, WEP_IDX_IRQ_MASK, 8'h02);
		kick(3'b010);
		`CHK("irq_set", 1'b1, irq)
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, k == 2 ? WEP_IDX_IRQ_STATUS : WEP_IDX_IRQ_MASK,
				k == 0 ? 8'h00 : 8'h02);
			#1;
			`CHK("irq", k == 1, irq)
		end
	endtask
	// key event during a status read survives the clear
	task t_race;
		@(posedge clk);
		{psel, penable, pwrite} <= 3'b100;
		paddr <= {WEP_IDX_EVT_STATUS, 2'b00};
		@(posedge clk);
		penable <= 1'b1;
		key_wake <= 1'b1;
		@(posedge clk);
		`CHK("race_rd", 8'h00, prdata[7:0])
		{psel, penable, key_wake} <= 3'b000;
		rchk(WEP_IDX_EVT_STATUS, 8'h01, "race_kept");
	endtask
	task results;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_reset;
		t_keys;
		t_live;
		t_events;
		t_loss;
		t_wake;
		t_race;
		t_irq;
		results;
	end
	initial begin
		#100000;
		errors++;
		results;
	end
endmodule
bind wep_regs wep_regs_assertions u_chk (.*);

// ===== bench/wep_regs_assertions.sv
`timescale 1ns/1ns
module wep_regs_assertions import wep_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [WEP_ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic key_wake,
	input wire logic pointer_wake,
	input wire logic power_restored,
	input wire logic any_key_mode,
	input wire logic hunting,
	input wire logic power_request_out_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// bus answer shape
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_phase: assert property (pslverr |-> psel && penable)
		else $error("pslverr outside access");
	a_rd_upper: assert property (prdata[31:8] == 24'h0)
		else $error("prdata upper bits set");
	a_rd_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
		else $error("prdata moved without read");
	// power request pulse
	a_req_cause: assert property ($fell(power_request_out_n) |-> $past(key_wake || pointer_wake || power_restored))
		else $error("power request without cause");
	a_req_pulse: assert property (!power_request_out_n && !key_wake && !pointer_wake && !power_restored |=> power_request_out_n)
		else $error("power request too long");
	// wake option bits
	a_hunt_clear: assert property (hunting && (key_wake || pointer_wake) && !(psel && penable && pwrite) |=> !hunting)
		else $error("hunting not cleared");
	a_mode_hold: assert property ($changed(any_key_mode) |-> $past(psel && penable && pwrite && paddr[9:2] == WEP_IDX_LOSS_CTRL))
		else $error("any key mode moved");
endmodule

// ===== rtl/wep_pkg.sv
package wep_pkg;
	// register indices; byte address is index times four
	localparam logic [7:0] WEP_IDX_KEY_INDEX = 8'hE1;
	localparam logic [7:0] WEP_IDX_KEY_DATA = 8'hE2;
	localparam logic [7:0] WEP_IDX_EVT_STATUS = 8'hE3;
	localparam logic [7:0] WEP_IDX_LOSS_CTRL = 8'hE4;
	localparam logic [7:0] WEP_IDX_SPARE = 8'hE5;
	localparam logic [7:0] WEP_IDX_WAKE_CTRL = 8'hE8;
	localparam logic [7:0] WEP_IDX_IRQ_STATUS = 8'hE9;
	localparam logic [7:0] WEP_IDX_IRQ_MASK = 8'hEA;
	localparam int WEP_ADDR_W = 10;
	localparam int WEP_ADDR_LSB = 2;
	// key storage windows
	localparam logic [7:0] WEP_SET1_BASE = 8'h00;
	localparam logic [7:0] WEP_LIVE_BASE = 8'h10;
	localparam logic [7:0] WEP_SET2_BASE = 8'h30;
	localparam logic [7:0] WEP_SET3_BASE = 8'h40;
	localparam logic [7:0] WEP_WIN_LEN = 8'h0F;
	localparam int WEP_KEYS_PER_SET = 15;
	localparam int WEP_KEY_SLOTS = 45;
	localparam logic [5:0] WEP_SET2_SLOT = 6'h0F;
	localparam logic [5:0] WEP_SET3_SLOT = 6'h1E;
	// event status bits
	localparam int WEP_EV_KEY = 0;
	localparam int WEP_EV_PTR = 1;
	localparam int WEP_EV_PANEL = 2;
	localparam int WEP_EV_THERM = 3;
	localparam int WEP_EV_LOSS = 4;
	localparam int WEP_EV_STBY = 5;
	localparam int WEP_EV_N = 6;
	// power-loss control fields
	localparam int WEP_LC_EN = 7;
	localparam int WEP_LC_POL_HI = 6;
	localparam int WEP_LC_POL_LO = 5;
	localparam int WEP_LC_ANYKEY = 3;
	localparam int WEP_LC_HUNT = 2;
	// wake control fields
	localparam int WEP_WC_KEY_EN = 6;
	localparam int WEP_WC_PTR_EN = 5;
	localparam int WEP_WC_LAST_OFF = 4;
	// reset values
	localparam logic [7:0] WEP_KEY_RST = 8'hFF;
	localparam logic [5:0] WEP_EVT_RST = 6'h08;
	localparam logic [7:0] WEP_INDEX_RST = 8'h00;
	localparam logic [31:0] WEP_RD_IDLE = 32'h0000_0000;
	// recovery policies
	typedef enum logic [1:0] {
		WEP_POL_OFF,
		WEP_POL_ON,
		WEP_POL_PREV,
		WEP_POL_USER
	} wep_policy_t;
	localparam int WEP_SYNC_N = 3;
	localparam int WEP_PIN_STBY = 0;
	localparam int WEP_PIN_THERM = 1;
	localparam int WEP_PIN_PANEL = 2;
endpackage

// ===== rtl/wep_regs.sv
// Our own choice: register access over APB.
`timescale 1ns/1ns
// Overview of operation
// - index addresses three stored key sets
// - index 10h-1Eh reads incoming key characters
// - data register accesses indexed key, resets FFh
// - bit5 latches standby power cycle, read-clears
// - bit4 shows restore-off decision when enabled
// - bit3 latches thermal shutdown, resets set
// - bit2 latches panel switch event
// - bit1 latches pointer wake event
// - bit0 latches keyboard wake event
// - control bit7 enables power-loss recovery
// - bits6-5 choose off, on, previous, user
// - option bit3 selects any-key wake
// - hunting bit2 clears on any wake
// - user last-state flag: 0 on, 1 off
// - key wake requests power only when enabled
module wep_regs import wep_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [WEP_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic standby_supply,
	input wire logic thermal_shutdown,
	input wire logic panel_switch_input,
	input wire logic key_wake,
	input wire logic pointer_wake,
	input wire logic key_code_valid,
	input wire logic [7:0] key_code,
	input wire logic power_restored,
	input wire logic prior_state_on,
	output logic any_key_mode,
	output logic hunting,
	output logic power_request_out_n,
	output logic irq
);
	// all block state in one record
	typedef struct packed {
		// pin synchronisers, third stage for edge detect
		logic [WEP_SYNC_N-1:0] s1;
		logic [WEP_SYNC_N-1:0] s2;
		logic [WEP_SYNC_N-1:0] s3;

		// key window and storage
		logic [7:0] index;
		logic [WEP_KEY_SLOTS-1:0][7:0] keys;
		logic [WEP_KEYS_PER_SET-1:0][7:0] live;

		// event flags and options
		logic [WEP_EV_N-1:0] status;
		logic loss_en;
		logic [1:0] policy;
		logic any_key;
		logic hunt;
		logic key_en;
		logic ptr_en;
		logic last_off;

		// interrupt side
		logic [WEP_EV_N-1:0] irq_sts;
		logic [WEP_EV_N-1:0] irq_mask;

		// bus read data and power request
		logic [31:0] rdata;
		logic preq;
	} wep_state_t;

	// registered state and its next value
	wep_state_t st_r;
	wep_state_t st_nxt;

	// bus decode helpers
	logic [7:0] idx;
	logic setup;
	logic access;
	logic mapped;

	// key window decode
	logic key_hit;
	logic [5:0] key_slot;
	logic live_hit;
	logic [3:0] live_slot;
	logic [7:0] key_rd;
	logic [7:0] reg_rd;

	// event and decision helpers
	logic [WEP_EV_N-1:0] ev;
	logic [WEP_EV_N-1:0] status_view;
	logic decide_off;

	// bus decode
	assign idx = paddr[WEP_ADDR_LSB +: 8];
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = st_r.rdata;
	assign any_key_mode = st_r.any_key;
	assign hunting = st_r.hunt;
	assign power_request_out_n = ~st_r.preq;
	assign irq = |(st_r.irq_sts & st_r.irq_mask);

	// known register indices, others answer with an error
	always_comb begin
		mapped = 1'b0;
		case (idx)
			WEP_IDX_KEY_INDEX: mapped = 1'b1;
			WEP_IDX_KEY_DATA: mapped = 1'b1;
			WEP_IDX_EVT_STATUS: mapped = 1'b1;
			WEP_IDX_LOSS_CTRL: mapped = 1'b1;
			WEP_IDX_SPARE: mapped = 1'b1;
			WEP_IDX_WAKE_CTRL: mapped = 1'b1;
			WEP_IDX_IRQ_STATUS: mapped = 1'b1;
			WEP_IDX_IRQ_MASK: mapped = 1'b1;
			default: mapped = 1'b0;
		endcase
	end

	// index to storage slot
	// three stored sets share one flat slot array;
	// set two and three follow set one back to back
	// the live window is read only and never stored;
	// indices outside every window read as erased keys
	always_comb begin
		key_hit = 1'b0;
		key_slot = 6'h00;
		live_hit = 1'b0;
		live_slot = st_r.index[3:0];
		if (st_r.index < WEP_SET1_BASE + WEP_WIN_LEN) begin
			key_hit = 1'b1;
			key_slot = st_r.index[5:0];
		end else if (st_r.index >= WEP_SET2_BASE &&
				st_r.index < WEP_SET2_BASE + WEP_WIN_LEN) begin
			key_hit = 1'b1;
			key_slot = 6'(st_r.index - WEP_SET2_BASE) + WEP_SET2_SLOT;
		end else if (st_r.index >= WEP_SET3_BASE &&
				st_r.index < WEP_SET3_BASE + WEP_WIN_LEN) begin
			key_hit = 1'b1;
			key_slot = 6'(st_r.index - WEP_SET3_BASE) + WEP_SET3_SLOT;
		end else if (st_r.index >= WEP_LIVE_BASE &&
				st_r.index < WEP_LIVE_BASE + WEP_WIN_LEN) begin
			live_hit = 1'b1;
		end
		if (key_hit) begin
			key_rd = st_r.keys[key_slot];
		end else if (live_hit) begin
			key_rd = st_r.live[live_slot];
		end else begin
			key_rd = WEP_KEY_RST;
		end
	end

	// restore decision from policy
	always_comb begin
		case (wep_policy_t'(st_r.policy))
			WEP_POL_OFF: decide_off = 1'b1;
			WEP_POL_ON: decide_off = 1'b0;
			WEP_POL_PREV: decide_off = ~prior_state_on;
			WEP_POL_USER: decide_off = st_r.last_off;
			default: decide_off = 1'b1;
		endcase
	end

	// status as software sees it
	always_comb begin
		status_view = st_r.status;
		status_view[WEP_EV_LOSS] = st_r.status[WEP_EV_LOSS] & st_r.loss_en;
	end

	// read mux
	always_comb begin
		reg_rd = 8'h00;
		case (idx)
			WEP_IDX_KEY_INDEX: reg_rd = st_r.index;
			WEP_IDX_KEY_DATA: reg_rd = key_rd;
			WEP_IDX_EVT_STATUS: reg_rd = {2'b00, status_view};
			WEP_IDX_LOSS_CTRL: begin
				reg_rd[WEP_LC_EN] = st_r.loss_en;
				reg_rd[WEP_LC_POL_HI:WEP_LC_POL_LO] = st_r.policy;
				reg_rd[WEP_LC_ANYKEY] = st_r.any_key;
				reg_rd[WEP_LC_HUNT] = st_r.hunt;
			end
			WEP_IDX_WAKE_CTRL: begin
				reg_rd[WEP_WC_KEY_EN] = st_r.key_en;
				reg_rd[WEP_WC_PTR_EN] = st_r.ptr_en;
				reg_rd[WEP_WC_LAST_OFF] = st_r.last_off;
			end
			WEP_IDX_IRQ_STATUS: reg_rd = {2'b00, st_r.irq_sts};
			WEP_IDX_IRQ_MASK: reg_rd = {2'b00, st_r.irq_mask};
			default: reg_rd = 8'h00;
		endcase
	end

	// events from pins (rising edges after sync) and from matchers
	always_comb begin
		ev = '0;
		ev[WEP_EV_KEY] = key_wake;
		ev[WEP_EV_PTR] = pointer_wake;
		ev[WEP_EV_PANEL] = st_r.s2[WEP_PIN_PANEL] &
			~st_r.s3[WEP_PIN_PANEL];
		ev[WEP_EV_THERM] = st_r.s2[WEP_PIN_THERM] &
			~st_r.s3[WEP_PIN_THERM];
		ev[WEP_EV_LOSS] = power_restored & st_r.loss_en & decide_off;
		ev[WEP_EV_STBY] = st_r.s2[WEP_PIN_STBY] &
			~st_r.s3[WEP_PIN_STBY];
	end

	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = {panel_switch_input, thermal_shutdown, standby_supply};
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.preq = 1'b0;
		// read snapshot taken in setup, held through access
		if (setup && !pwrite) begin
			st_nxt.rdata = {24'h000000, reg_rd};
		end
		// read-clear of only returned ones
		if (access && !pwrite && idx == WEP_IDX_EVT_STATUS) begin
			st_nxt.status = st_r.status &
				~st_r.rdata[WEP_EV_N-1:0];
		end
		// bit4 is shown gated, clear the raw flag whenever read while gated
		if (access && !pwrite && idx == WEP_IDX_EVT_STATUS &&
				!st_r.loss_en) begin
			st_nxt.status[WEP_EV_LOSS] = 1'b0;
		end
		// register writes at the end of access
		if (access && pwrite) begin
			case (idx)
				WEP_IDX_KEY_INDEX: st_nxt.index = pwdata[7:0];
				WEP_IDX_KEY_DATA: begin
					if (key_hit) begin
						st_nxt.keys[key_slot] = pwdata[7:0];
					end
				end
				WEP_IDX_LOSS_CTRL: begin
					st_nxt.loss_en = pwdata[WEP_LC_EN];
					st_nxt.policy = pwdata[WEP_LC_POL_HI:WEP_LC_POL_LO];
					st_nxt.any_key = pwdata[WEP_LC_ANYKEY];
					st_nxt.hunt = pwdata[WEP_LC_HUNT];
				end
				WEP_IDX_WAKE_CTRL: begin
					st_nxt.key_en = pwdata[WEP_WC_KEY_EN];
					st_nxt.ptr_en = pwdata[WEP_WC_PTR_EN];
					st_nxt.last_off = pwdata[WEP_WC_LAST_OFF];
				end
				WEP_IDX_IRQ_STATUS: st_nxt.irq_sts =
					st_r.irq_sts & ~pwdata[WEP_EV_N-1:0];
				WEP_IDX_IRQ_MASK: st_nxt.irq_mask = pwdata[WEP_EV_N-1:0];
				default: st_nxt.index = st_r.index;
			endcase
		end
		// incoming key history, newest at slot 0
		if (key_code_valid) begin
			st_nxt.live = {st_r.live[WEP_KEYS_PER_SET-2:0], key_code};
		end
		// events set, winning over any clear
		st_nxt.status = st_nxt.status | ev;
		st_nxt.irq_sts = st_nxt.irq_sts | ev;
		// any captured wake ends hunting
		if (key_wake || pointer_wake || ev[WEP_EV_PANEL]) begin
			st_nxt.hunt = 1'b0;
		end
		// power request pulse
		if ((key_wake && st_r.key_en) ||
				(pointer_wake && st_r.ptr_en) ||
				(power_restored && st_r.loss_en && !decide_off)) begin
			st_nxt.preq = 1'b1;
		end
	end

	// state register with sync reset and clock enable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			// synchronisers at pin idle levels, no false edge
			st_r.s1 <= '0;
			st_r.s2 <= '0;
			st_r.s3 <= '0;
			st_r.s1[WEP_PIN_STBY] <= 1'b1; // supply idles high
			st_r.s2[WEP_PIN_STBY] <= 1'b1;
			st_r.s3[WEP_PIN_STBY] <= 1'b1;

			// key window and storage
			st_r.index <= WEP_INDEX_RST;
			st_r.keys <= {WEP_KEY_SLOTS{WEP_KEY_RST}};
			st_r.live <= {WEP_KEYS_PER_SET{WEP_KEY_RST}};

			// event status, thermal bit set
			st_r.status <= WEP_EVT_RST;

			// power-loss and wake options
			st_r.loss_en <= 1'b0;
			st_r.policy <= '0;
			st_r.any_key <= 1'b0;
			st_r.hunt <= 1'b0;
			st_r.key_en <= 1'b0;
			st_r.ptr_en <= 1'b0;
			st_r.last_off <= 1'b0;

			// interrupt side
			st_r.irq_sts <= '0;
			st_r.irq_mask <= '0;

			// bus read data and power request
			st_r.rdata <= WEP_RD_IDLE;
			st_r.preq <= 1'b0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end
endmodule
